// *** core/t1rx_status.v ***
// Receive alarm, line event and sync output logic for one T1 port.
//
// Summary of operation
// - Shift enable bit drives backplane sync shifting.
// - Skip bit halves multiframe sync pulses.
// - T1 frame mode: double-wide signaling-frame pulses.
// - E1 multiframe mode: CAS or CRC4 boundaries.
// - First mode bit: frame or multiframe pulses.
// - Remote alarm and AIS bits follow, unlatched.
// - Signal loss after 192 consecutive line zeros.
// - Frame loss while framer out of sync.
// - Alarm rises and falls latch separate events.
// - Alarm mask bits enable summary interrupts, reset zero.
// - Line events latch but never interrupt.
// - Latch pulse density violation event.
// - Latch change of frame alignment event.
// - Latch eight-zero and sixteen-zero runs.
// - Latch severely errored framing event.
// - Latch B8ZS codeword, decoding on or off.
// - Latch every framing bit error.
// - Clock loss after eight idle bit periods.
// - Live spare, loop-down, loop-up code bits.
// - Clock and code edges latch events.
// - All config, event, mask bits reset zero.
// - Masked events stay out of summary bits.
`timescale 1ns/100ps
`include "t1rx_regs.vh"

module t1rx_status
(
  input  wire        clock,
  input  wire        rst_b,
  input  wire [15:0] reg_addr,
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [7:0]  reg_wr_data,
  output reg  [7:0]  reg_rd_data,
  input  wire        rx_line_clock,
  input  wire        line_positive_input,
  input  wire        line_negative_input,
  input  wire        remote_alarm_cond,
  input  wire        all_ones_cond,
  input  wire        framer_in_sync,
  input  wire        e1_mode,
  input  wire        pulse_density_pulse,
  input  wire        alignment_change_pulse,
  input  wire        severe_framing_pulse,
  input  wire        frame_bit_error_pulse,
  input  wire        spare_code_match,
  input  wire        loop_down_code_match,
  input  wire        loop_up_code_match,
  input  wire        frame_boundary,
  input  wire        multiframe_boundary,
  input  wire        crc4_multiframe_boundary,
  input  wire        signaling_frame,
  output reg         receive_sync_pin,
  output wire        sync_shift_enable,
  output wire        backplane_clock_rate_select,
  output wire [1:0]  rx_interrupt_summary
);

  localparam CHANNEL_CYCLES = `T1RX_CHANNEL_CYCLES;
  localparam [2:0] SYNC_IDLE  = 3'b001;
  localparam [2:0] SYNC_LAST  = 3'b010;
  localparam [2:0] SYNC_FIRST = 3'b100;

  // Registers visible to the host.
  reg [7:0] io_cfg_r;
  reg [7:0] alarm_evt_r;
  reg [7:0] line_evt_r;
  reg [7:0] code_evt_r;
  reg [7:0] alarm_mask_r;
  reg [7:0] code_mask_r;

  // Pin synchronisers.
  reg [1:0] clk_sync_r;
  reg [1:0] pos_sync_r;
  reg [1:0] neg_sync_r;
  reg       clk_seen_r;

  // Line monitoring state.
  reg [7:0] zero_run_r;
  reg [8:0] idle_cnt_r;
  reg       clock_loss_r;
  reg [7:0] hist_pos_r;
  reg [7:0] hist_neg_r;
  reg       pol_before_r;

  // Previous live values for edge detection.
  reg [3:0] alarm_prev_r;
  reg [3:0] code_prev_r;

  // Sync output state.
  reg [2:0] sync_state_r;
  reg [2:0] sync_state_nxt;
  reg       mf_toggle_r;

  wire       bit_edge;
  wire       line_pos;
  wire       line_neg;
  wire       line_zero;
  wire       los_live;
  wire [3:0] alarm_live;
  wire [3:0] code_live;
  wire [7:0] alarm_set;
  wire [7:0] line_set;
  wire [7:0] code_set;
  wire [7:0] win_pos;
  wire [7:0] win_neg;
  wire       b8zs_hit;
  wire       wr_alarm_evt;
  wire       wr_line_evt;
  wire       wr_code_evt;
  wire       mf_pick;
  wire       mf_mode;
  wire       wide_frame;
  reg        sync_start;
  reg        sync_wide;

  // W1C update: a new event always wins over the host's clear.
  function [7:0] w1c_next;
    input [7:0] cur;
    input [7:0] set;
    input       wr;
    input [7:0] data;
    begin
      w1c_next = (cur & ~(wr ? data : 8'h00)) | set;
    end
  endfunction

  // Rising and falling edges packed as {falls, rises}.
  function [7:0] edge_events;
    input [3:0] live;
    input [3:0] prev;
    begin
      edge_events = {~live & prev, live & ~prev};
    end
  endfunction

  assign line_pos  = pos_sync_r[1];
  assign line_neg  = neg_sync_r[1];
  assign line_zero = ~line_pos & ~line_neg;
  assign bit_edge  = clk_sync_r[1] & ~clk_seen_r;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      clk_sync_r <= 2'h0;
      pos_sync_r <= 2'h0;
      neg_sync_r <= 2'h0;
      clk_seen_r <= 1'b0;
    end
    else
    begin
      clk_sync_r <= {clk_sync_r[0], rx_line_clock};
      pos_sync_r <= {pos_sync_r[0], line_positive_input};
      neg_sync_r <= {neg_sync_r[0], line_negative_input};
      clk_seen_r <= clk_sync_r[1];
    end
  end

  // Zero runs are counted on each received bit and saturate past the loss threshold.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      zero_run_r <= 8'h00;
    else if (bit_edge)
    begin
      if (!line_zero)
        zero_run_r <= 8'h00;
      else if (zero_run_r != 8'hff)
        zero_run_r <= zero_run_r + 8'h01;
    end
  end

  assign los_live = (zero_run_r >= `T1RX_LOS_ZEROS);

  // Clock loss: no rising or falling edge of the line clock for one channel time.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      idle_cnt_r   <= 9'h000;
      clock_loss_r <= 1'b0;
    end
    else if (clk_sync_r[1] != clk_seen_r)
    begin
      idle_cnt_r   <= 9'h000;
      clock_loss_r <= 1'b0;
    end
    else if (idle_cnt_r >= CHANNEL_CYCLES[8:0] - 9'h001)
      clock_loss_r <= 1'b1;
    else
      idle_cnt_r <= idle_cnt_r + 9'h001;
  end

  // Eight-bit window of received pulses for codeword search.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hist_pos_r   <= 8'h00;
      hist_neg_r   <= 8'h00;
      pol_before_r <= 1'b0;
    end
    else if (bit_edge)
    begin
      hist_pos_r <= {hist_pos_r[6:0], line_pos};
      hist_neg_r <= {hist_neg_r[6:0], line_neg};
      if (hist_pos_r[7] | hist_neg_r[7])
        pol_before_r <= hist_pos_r[7];
    end
  end

  // Newest bit at index 0; pattern oldest first is 0 0 0 V B 0 V B.
  assign win_pos = hist_pos_r;
  assign win_neg = hist_neg_r;
  assign b8zs_hit = ((win_pos | win_neg) == 8'h1b)
                  && ((win_pos & win_neg) == 8'h00)
                  && (win_pos[4] == pol_before_r)
                  && (win_pos[3] != win_pos[4])
                  && (win_pos[1] == win_pos[3])
                  && (win_pos[0] != win_pos[1]);

  assign alarm_live = {remote_alarm_cond, all_ones_cond,
                       los_live, ~framer_in_sync};
  assign code_live  = {clock_loss_r, spare_code_match,
                       loop_down_code_match, loop_up_code_match};

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alarm_prev_r <= 4'h0;
      code_prev_r  <= 4'h0;
    end
    else
    begin
      alarm_prev_r <= alarm_live;
      code_prev_r  <= code_live;
    end
  end

  assign alarm_set = edge_events(alarm_live, alarm_prev_r);
  assign code_set  = edge_events(code_live, code_prev_r);

  assign line_set[`T1RX_LINE_PDV]    = pulse_density_pulse;
  assign line_set[6]                 = 1'b0;
  assign line_set[`T1RX_LINE_ALIGN]  = alignment_change_pulse;
  assign line_set[`T1RX_LINE_ZERO8]  = bit_edge & line_zero
                                     & (zero_run_r == `T1RX_ZERO_RUN_SHORT - 1);
  assign line_set[`T1RX_LINE_ZERO16] = bit_edge & line_zero
                                     & (zero_run_r == `T1RX_ZERO_RUN_LONG - 1);
  assign line_set[`T1RX_LINE_SEVERE] = severe_framing_pulse;
  assign line_set[`T1RX_LINE_B8ZS]   = bit_edge & b8zs_hit;
  assign line_set[`T1RX_LINE_FBIT]   = frame_bit_error_pulse;

  assign wr_alarm_evt = reg_wr_en & (reg_addr == `T1RX_ADDR_ALARM_EVT);
  assign wr_line_evt  = reg_wr_en & (reg_addr == `T1RX_ADDR_LINE_EVT);
  assign wr_code_evt  = reg_wr_en & (reg_addr == `T1RX_ADDR_CODE_EVT);

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      io_cfg_r     <= `T1RX_RESET_VAL;
      alarm_evt_r  <= `T1RX_RESET_VAL;
      line_evt_r   <= `T1RX_RESET_VAL;
      code_evt_r   <= `T1RX_RESET_VAL;
      alarm_mask_r <= `T1RX_RESET_VAL;
      code_mask_r  <= `T1RX_RESET_VAL;
    end
    else
    begin
      alarm_evt_r <= w1c_next(alarm_evt_r, alarm_set, wr_alarm_evt, reg_wr_data);
      line_evt_r  <= w1c_next(line_evt_r, line_set, wr_line_evt, reg_wr_data);
      code_evt_r  <= w1c_next(code_evt_r, code_set, wr_code_evt, reg_wr_data);
      if (reg_wr_en && reg_addr == `T1RX_ADDR_IO_CFG)
        io_cfg_r <= reg_wr_data & 8'hfb;
      if (reg_wr_en && reg_addr == `T1RX_ADDR_ALARM_MASK)
        alarm_mask_r <= reg_wr_data;
      if (reg_wr_en && reg_addr == `T1RX_ADDR_CODE_MASK)
        code_mask_r <= reg_wr_data;
    end
  end

  // Read data is registered and holds until the next read.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      reg_rd_data <= `T1RX_RESET_VAL;
    else if (reg_rd_en)
    begin
      case (reg_addr)
        `T1RX_ADDR_IO_CFG:     reg_rd_data <= io_cfg_r;
        `T1RX_ADDR_ALARM_EVT:  reg_rd_data <= alarm_evt_r;
        `T1RX_ADDR_LINE_EVT:   reg_rd_data <= line_evt_r;
        `T1RX_ADDR_CODE_EVT:   reg_rd_data <= code_evt_r;
        `T1RX_ADDR_ALARM_MASK: reg_rd_data <= alarm_mask_r;
        `T1RX_ADDR_CODE_MASK:  reg_rd_data <= code_mask_r;
        `T1RX_ADDR_ALARM_LIVE: reg_rd_data <= {4'h0, alarm_live};
        `T1RX_ADDR_CODE_LIVE:  reg_rd_data <= {4'h0, code_live};
        default:               reg_rd_data <= `T1RX_UNMAPPED_VAL;
      endcase
    end
  end

  // Line events never reach the summary; bit 1 carries the clock and code events.
  assign rx_interrupt_summary[0] = |(alarm_evt_r & alarm_mask_r);
  assign rx_interrupt_summary[1] = |(code_evt_r & code_mask_r);

  // The backplane logic uses these two bits; the host keeps them matched.
  assign sync_shift_enable           = io_cfg_r[`T1RX_IO_SHIFT_EN];
  assign backplane_clock_rate_select = io_cfg_r[`T1RX_IO_CLK_RATE];

  assign mf_mode    = io_cfg_r[`T1RX_IO_MODE_FIRST];
  assign mf_pick    = (e1_mode && io_cfg_r[`T1RX_IO_MODE_SECOND])
                    ? crc4_multiframe_boundary
                    : multiframe_boundary;
  assign wide_frame = ~e1_mode & io_cfg_r[`T1RX_IO_MODE_SECOND]
                    & signaling_frame;

  // Toggle picks every other multiframe when skipping is on.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      mf_toggle_r <= 1'b0;
    else if (mf_mode && mf_pick)
      mf_toggle_r <= ~mf_toggle_r;
  end

  always @*
  begin
    sync_start = 1'b0;
    sync_wide  = 1'b0;
    if (mf_mode)
      sync_start = mf_pick
                 & (~io_cfg_r[`T1RX_IO_MF_SKIP] | ~mf_toggle_r);
    else
    begin
      sync_start = frame_boundary;
      sync_wide  = wide_frame;
    end
  end

  // Pulse lasts one bit period, or two when double wide.
  always @*
  begin
    sync_state_nxt = sync_state_r;
    case (sync_state_r)
      SYNC_IDLE:
      begin
        if (sync_start)
          sync_state_nxt = sync_wide ? SYNC_FIRST : SYNC_LAST;
      end
      SYNC_FIRST:
      begin
        if (bit_edge)
          sync_state_nxt = SYNC_LAST;
      end
      SYNC_LAST:
      begin
        if (bit_edge)
          sync_state_nxt = SYNC_IDLE;
      end
      default:
        sync_state_nxt = SYNC_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_state_r     <= SYNC_IDLE;
      receive_sync_pin <= 1'b0;
    end
    else
    begin
      sync_state_r     <= sync_state_nxt;
      receive_sync_pin <= (sync_state_nxt != SYNC_IDLE)
                        ^ io_cfg_r[`T1RX_IO_SYNC_INVERT];
    end
  end

endmodule

// *** core/t1rx_regs.vh ***
// Register offsets, field positions, reset values and timing counts.
`ifndef T1RX_REGS_VH
`define T1RX_REGS_VH

`define T1RX_ADDR_IO_CFG     16'h0084
`define T1RX_ADDR_ALARM_EVT  16'h0090
`define T1RX_ADDR_LINE_EVT   16'h0091
`define T1RX_ADDR_CODE_EVT   16'h0092
`define T1RX_ADDR_ALARM_MASK 16'h00a0
`define T1RX_ADDR_CODE_MASK  16'h00a2
`define T1RX_ADDR_ALARM_LIVE 16'h00b0
`define T1RX_ADDR_CODE_LIVE  16'h00b2

`define T1RX_RESET_VAL       8'h00
`define T1RX_UNMAPPED_VAL    8'h00

`define T1RX_IO_SYNC_INVERT  6
`define T1RX_IO_SHIFT_EN     5
`define T1RX_IO_CLK_RATE     4
`define T1RX_IO_MF_SKIP      3
`define T1RX_IO_MODE_SECOND  1
`define T1RX_IO_MODE_FIRST   0

`define T1RX_LINE_PDV        7
`define T1RX_LINE_ALIGN      5
`define T1RX_LINE_ZERO8      4
`define T1RX_LINE_ZERO16     3
`define T1RX_LINE_SEVERE     2
`define T1RX_LINE_B8ZS       1
`define T1RX_LINE_FBIT       0

`define T1RX_LOS_ZEROS       192
`define T1RX_ZERO_RUN_SHORT  8
`define T1RX_ZERO_RUN_LONG   16
`define T1RX_CLK_PERIOD_NS   20
`define T1RX_CHANNEL_TIME_NS 5180
`define T1RX_CHANNEL_CYCLES  (`T1RX_CHANNEL_TIME_NS / `T1RX_CLK_PERIOD_NS)

`endif

// *** sim/t1rx_line_model.sv ***
// Line side model: receive line clock and bipolar line data.
`timescale 1ns/100ps
module t1rx_line_model
(
  input  wire run,
  input  wire mark,
  input  wire subst,
  output reg  line_clock,
  output reg  pos,
  output reg  neg
);
  reg       pol  = 1'b0;
  reg [3:0] step = 4'h8;
  // The clock stands still while run is low, as a lost line clock would.
  initial
  begin
    {line_clock, pos, neg} = 3'b000;
    #7;
    forever #80 line_clock = run ? ~line_clock : line_clock;
  end
  // Marks alternate between the rails; subst sends one codeword 000VB0VB whose
  // violations repeat the polarity of the pulse before them.
  always @(negedge line_clock)
  begin
    if (subst && step == 4'h8)
      step = 4'h0;
    if (step == 4'h8)
    begin
      pol = ~pol;
      {pos, neg} = {mark & pol, mark & ~pol};
    end
    else
    begin
      if (step == 4'h4 || step == 4'h7)
        pol = ~pol;
      if (step == 4'h3 || step == 4'h4 || step == 4'h6 || step == 4'h7)
        {pos, neg} = {pol, ~pol};
      else
        {pos, neg} = 2'b00;
      step = step + 4'h1;
    end
  end
endmodule

// *** sim/t1rx_status_monitor.sv ***
// Port level assertions for the receive status block.
`timescale 1ns/100ps
module t1rx_status_monitor
(
  input wire        clock,
  input wire        rst_b,
  input wire [15:0] reg_addr,
  input wire        reg_wr_en,
  input wire        reg_rd_en,
  input wire [7:0]  reg_wr_data,
  input wire [7:0]  reg_rd_data,
  input wire        remote_alarm_cond,
  input wire        framer_in_sync,
  input wire        frame_boundary,
  input wire        receive_sync_pin,
  input wire        sync_shift_enable,
  input wire [1:0]  rx_interrupt_summary
);
  reg  [7:0] io_r;
  reg  [7:0] mask_r;
  wire       rd_live = reg_rd_en && reg_addr == 16'h00b0;
  // Shadows of the io configuration and alarm mask registers.
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      io_r   <= 8'h00;
      mask_r <= 8'h00;
    end
    else if (reg_wr_en)
    begin
      io_r   <= (reg_addr == 16'h0084) ? reg_wr_data : io_r;
      mask_r <= (reg_addr == 16'h00a0) ? reg_wr_data : mask_r;
    end
  default clocking mon_cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  a_reset_quiet: assert property (
    disable iff (1'b0) !rst_b |-> rx_interrupt_summary == 2'b00 && !receive_sync_pin)
    else $error("outputs active in reset");
  a_cfg_follows: assert property (
    reg_wr_en && reg_addr == 16'h0084 |=> sync_shift_enable == $past(reg_wr_data[5]))
    else $error("shift enable wrong after write");
  a_lof_live: assert property (
    rd_live && !framer_in_sync && !$past(framer_in_sync) |=> reg_rd_data[0])
    else $error("frame loss bit low");
  a_rai_live: assert property (
    rd_live && $stable(remote_alarm_cond) |=> reg_rd_data[3] == $past(remote_alarm_cond))
    else $error("remote alarm bit wrong");
  a_alarm_masked: assert property (
    mask_r == 8'h00 |-> !rx_interrupt_summary[0])
    else $error("masked alarm in summary");
  a_line_quiet: assert property (
    reg_rd_en && reg_addr == 16'h0091 |=> !reg_rd_data[6])
    else $error("line event spare bit set");
  a_frame_sync: assert property (
    frame_boundary && !io_r[0] && !io_r[6] |=> receive_sync_pin)
    else $error("no sync pulse on frame");
  a_live_upper: assert property (
    rd_live |=> reg_rd_data[7:4] == 4'h0)
    else $error("live status upper bits set");
endmodule
bind t1rx_status t1rx_status_monitor i_t1rx_status_monitor
(
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
  .reg_rd_en(reg_rd_en), .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
  .remote_alarm_cond(remote_alarm_cond), .framer_in_sync(framer_in_sync),
  .frame_boundary(frame_boundary), .receive_sync_pin(receive_sync_pin),
  .sync_shift_enable(sync_shift_enable), .rx_interrupt_summary(rx_interrupt_summary)
);

// *** sim/t1rx_status_bench.sv ***
// Register level tests of the receive status block.
`timescale 1ns/100ps
module t1rx_status_bench;
  reg        clock = 1'b0, rst_b = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  reg        crc = 1'b0, e1 = 1'b0, sig = 1'b0, subst = 1'b0;
  reg        rac = 1'b0, aoc = 1'b0, insync = 1'b1, fb = 1'b0, mfb = 1'b0;
  reg        run = 1'b1, mark = 1'b1;
  reg [15:0] addr = 16'h0000;
  reg [7:0]  wdata = 8'h00;
  reg [3:0]  evp = 4'h0;
  reg [2:0]  code = 3'h0;
  wire       lclk, pos, neg, sync_pin, shift_en, rate_sel;
  wire [7:0] rdata;
  wire [1:0] summary;
  integer    n_errors = 0, n_compared = 0, n;
  always #10 clock = ~clock;
  t1rx_line_model i_t1rx_line_model
  (
    .run(run), .mark(mark), .subst(subst), .line_clock(lclk), .pos(pos), .neg(neg)
  );
  t1rx_status i_t1rx_status
  (
    .clock(clock), .rst_b(rst_b), .reg_addr(addr), .reg_wr_en(wr_en),
    .reg_rd_en(rd_en), .reg_wr_data(wdata), .reg_rd_data(rdata),
    .rx_line_clock(lclk), .line_positive_input(pos), .line_negative_input(neg),
    .remote_alarm_cond(rac), .all_ones_cond(aoc), .framer_in_sync(insync),
    .e1_mode(e1), .pulse_density_pulse(evp[3]), .alignment_change_pulse(evp[2]),
    .severe_framing_pulse(evp[1]), .frame_bit_error_pulse(evp[0]),
    .spare_code_match(code[2]), .loop_down_code_match(code[1]),
    .loop_up_code_match(code[0]), .frame_boundary(fb), .multiframe_boundary(mfb),
    .crc4_multiframe_boundary(crc), .signaling_frame(sig),
    .receive_sync_pin(sync_pin), .sync_shift_enable(shift_en),
    .backplane_clock_rate_select(rate_sel), .rx_interrupt_summary(summary)
  );
  task tick(input integer c);
    begin
      repeat (c) @(posedge clock);
      #1;
    end
  endtask
  task cmp(input [7:0] v, input [7:0] e);
    begin
      n_compared = n_compared + 1;
      if (v !== e)
        $display("mismatch at %0t: got %h expected %h", $time, v, e);
      n_errors = n_errors + (v !== e);
    end
  endtask
  task wr(input [15:0] a, input [7:0] d);
    begin
      {addr, wdata, wr_en} = {a, d, 1'b1};
      tick(1);
      wr_en = 1'b0;
    end
  endtask
  task chk(input [15:0] a, input [7:0] e);
    begin
      {addr, rd_en} = {a, 1'b1};
      tick(1);
      rd_en = 1'b0;
      tick(1);
      cmp(rdata, e);
    end
  endtask
  // Counts boundaries answered by a sync pulse on the following cycle.
  task sync_count(input [7:0] cfg, input [2:0] sel, input [7:0] e);
    begin
      wr(16'h0084, cfg);
      n = 0;
      repeat (4)
      begin
        {fb, mfb, crc} = sel;
        tick(1);
        {fb, mfb, crc} = 3'b000;
        n = n + (sync_pin === 1'b1);
        tick(30);
      end
      cmp(n[7:0], e);
    end
  endtask
  // Reports whether a signaling frame pulse stands longer than one bit period.
  task sync_width(input [7:0] cfg, input [7:0] e);
    begin
      wr(16'h0084, cfg);
      {fb, sig} = 2'b11;
      tick(1);
      {fb, sig} = 2'b00;
      n = 0;
      repeat (30)
      begin
        n = n + (sync_pin === 1'b1);
        tick(1);
      end
      cmp({7'h00, n > 8}, e);
    end
  endtask
  task conclude;
    begin
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #1;
    rst_b = 1'b0;
    tick(4);
    rst_b = 1'b1;
    tick(2);
    wr(16'h0084, 8'h3f);
    chk(16'h0084, 8'h3b);
    cmp({shift_en, rate_sel}, 2'b11);
    wr(16'h00a0, 8'hff);
    {rac, aoc, insync} = 3'b110;
    tick(4);
    chk(16'h00b0, 8'h0d);
    chk(16'h0090, 8'h0d);
    cmp(summary[0], 1'b1);
    wr(16'h00a0, 8'h00);
    cmp(summary[0], 1'b0);
    {rac, aoc, insync} = 3'b001;
    tick(4);
    chk(16'h0090, 8'hdd);
    wr(16'h0090, 8'hff);
    chk(16'h0090, 8'h00);
    wr(16'h00a0, 8'hff);
    evp = 4'hf;
    tick(1);
    evp = 4'h0;
    wr(16'h0091, 8'h00);
    chk(16'h0091, 8'ha5);
    cmp(summary, 2'b00);
    evp = 4'h1;
    wr(16'h0091, 8'hff);
    evp = 4'h0;
    chk(16'h0091, 8'h01);
    wr(16'h0091, 8'hff);
    tick(1);
    wr(16'h00a2, 8'h0f);
    code = 3'h7;
    tick(4);
    chk(16'h00b2, 8'h07);
    cmp(summary[1], 1'b1);
    code = 3'h0;
    tick(4);
    chk(16'h0092, 8'h77);
    wr(16'h0092, 8'hff);
    mark = 1'b0;
    tick(1440);
    chk(16'h00b0, 8'h00);
    tick(200);
    chk(16'h00b0, 8'h02);
    chk(16'h0091, 8'h18);
    mark = 1'b1;
    tick(40);
    chk(16'h0090, 8'h22);
    wr(16'h0091, 8'hff);
    subst = 1'b1;
    tick(8);
    subst = 1'b0;
    tick(100);
    chk(16'h0091, 8'h02);
    run = 1'b0;
    tick(240);
    chk(16'h00b2, 8'h00);
    tick(40);
    chk(16'h00b2, 8'h08);
    run = 1'b1;
    tick(20);
    chk(16'h0092, 8'h88);
    sync_count(8'h00, 3'b100, 8'h04);
    sync_count(8'h01, 3'b010, 8'h04);
    sync_count(8'h09, 3'b010, 8'h02);
    sync_width(8'h02, 8'h01);
    sync_width(8'h00, 8'h00);
    sync_count(8'h40, 3'b100, 8'h00);
    cmp(sync_pin, 1'b1);
    e1 = 1'b1;
    sync_count(8'h03, 3'b001, 8'h04);
    sync_count(8'h03, 3'b010, 8'h00);
    sync_count(8'h01, 3'b010, 8'h04);
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    cmp({shift_en, rate_sel}, 2'b00);
    chk(16'h0084, 8'h00);
    chk(16'h0092, 8'h00);
    chk(16'h00a0, 8'h00);
    chk(16'h0010, 8'h00);
    conclude;
  end
endmodule
